// *** pkg/dtc_pkg.sv ***
// Constants shared by the dual timer/counter block
`default_nettype none
package dtc_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_TIMER_CONTROL  = 8'h88;
	localparam logic [7:0] IDX_TIMER_MODE     = 8'h89;
	localparam logic [7:0] IDX_COUNTER_A_LOW  = 8'h8a;
	localparam logic [7:0] IDX_COUNTER_B_LOW  = 8'h8b;
	localparam logic [7:0] IDX_COUNTER_A_HIGH = 8'h8c;
	localparam logic [7:0] IDX_COUNTER_B_HIGH = 8'h8d;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] RST_TIMER_MODE    = 8'h00;
	localparam logic [7:0] RST_COUNTER       = 8'h00;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int BIT_OVERFLOW_FLAG_B = 7;
	localparam int BIT_RUN_BIT_B       = 6;
	localparam int BIT_OVERFLOW_FLAG_A = 5;
	localparam int BIT_RUN_BIT_A       = 4;
	localparam int BIT_EXT_IRQ_FLAG_B  = 3;
	localparam int BIT_EXT_IRQ_TYPE_B  = 2;
	localparam int BIT_EXT_IRQ_FLAG_A  = 1;
	localparam int BIT_EXT_IRQ_TYPE_A  = 0;

	// ----------------------------------------
	// Mode register fields (each unit: gate, select, mode[1:0])
	// ----------------------------------------
	localparam int POS_UNIT_B     = 4;
	localparam int POS_UNIT_A     = 0;
	localparam int OFS_GATE       = 3;
	localparam int OFS_SELECT     = 2;
	localparam int OFS_MODE       = 0;

	typedef enum logic [1:0] {
		DTC_MODE_PRESCALE = 2'h0,
		DTC_MODE_WIDE     = 2'h1,
		DTC_MODE_RELOAD   = 2'h2,
		DTC_MODE_SPLIT    = 2'h3
	} dtc_mode_t;

	// ----------------------------------------
	// Timing: one peripheral cycle is six system clocks
	// ----------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int PERIPH_CYCLE_NS  = 60;
	localparam int PERIPH_DIV       = PERIPH_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [4:0] PRESCALE_MAX = 5'h1f;

	// ----------------------------------------
	// AXI4-Lite responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// *** hw/dtc_sync.sv ***
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module dtc_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dtc_sync_state_t;

	dtc_sync_state_t s;
	dtc_sync_state_t next_s;

	// First stage feeds only the second stage
	always_comb
	begin
		next_s    = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.s2;

endmodule
`default_nettype wire

// *** hw/dtc_tick.sv ***
// Peripheral cycle enable divider
`timescale 1ns/1ns
`default_nettype none
module dtc_tick #(
	parameter int DIV = dtc_pkg::PERIPH_DIV
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// One-cycle enable per peripheral cycle
	output logic      tick
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} dtc_tick_state_t;

	localparam logic [7:0] LAST = 8'(DIV - 1);

	dtc_tick_state_t s;
	dtc_tick_state_t next_s;

	always_comb
	begin
		next_s      = s;
		next_s.tick = (s.cnt == LAST);
		if (s.cnt == LAST)
			next_s.cnt = 8'h00;
		else
			next_s.cnt = s.cnt + 8'h01;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;

endmodule
`default_nettype wire

// *** hw/dtc_top.sv ***
// Dual 16-bit timer/counter with external interrupt flags
`timescale 1ns/1ns
`default_nettype none
module dtc_top #(
	parameter int AXI_ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// AXI4-Lite write address
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// External pins
	input  wire logic                  count_pin_a,
	input  wire logic                  count_pin_b,
	input  wire logic                  ext_irq_pin_a_n,
	input  wire logic                  ext_irq_pin_b_n,
	// Interrupt vector acknowledges from the core
	input  wire logic                  vector_ack_timer_a,
	input  wire logic                  vector_ack_timer_b,
	input  wire logic                  vector_ack_ext_a,
	input  wire logic                  vector_ack_ext_b,
	// Interrupt requests
	output logic                       overflow_flag_a,
	output logic                       overflow_flag_b,
	output logic                       ext_irq_flag_a,
	output logic                       ext_irq_flag_b
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]            ctrl;
		logic [7:0]            tmode;
		logic [7:0]            a_lo;
		logic [7:0]            a_hi;
		logic [7:0]            b_lo;
		logic [7:0]            b_hi;
		logic [3:0]            pin_prev;
		logic                  aw_full;
		logic                  w_full;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic [7:0]            wbyte;
		logic                  wlane;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
	} dtc_state_t;

	localparam dtc_state_t RST_STATE = '{
		ctrl:   dtc_pkg::RST_TIMER_CONTROL,
		tmode:  dtc_pkg::RST_TIMER_MODE,
		a_lo:   dtc_pkg::RST_COUNTER,
		a_hi:   dtc_pkg::RST_COUNTER,
		b_lo:   dtc_pkg::RST_COUNTER,
		b_hi:   dtc_pkg::RST_COUNTER,
		default: '0
	};

	dtc_state_t s;
	dtc_state_t next_s;
	logic [1:0] rst_pipe;
	logic       rst_n;
	logic [3:0] pin_q;
	logic       tick;

	// ----------------------------------------
	// Reset release, pin synchronisers, divider
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	dtc_sync #(
		.W (4)
	) i_dtc_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({ext_irq_pin_b_n, ext_irq_pin_a_n, count_pin_b, count_pin_a}),
		.q     (pin_q)
	);

	dtc_tick #(
		.DIV (dtc_pkg::PERIPH_DIV)
	) i_dtc_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	// ----------------------------------------
	// One count step for modes zero to two
	// ----------------------------------------
	// Returns {overflow, high, low}
	function automatic logic [16:0] step(
		input logic [1:0] m,
		input logic [7:0] h,
		input logic [7:0] l
	);
		logic [16:0] r;
		logic [16:0] wide;
		logic [8:0]  lo9;
		r    = {1'b0, h, l};
		wide = {1'b0, h, l} + 17'h00001;
		lo9  = {1'b0, l} + 9'h001;
		case (m)
			dtc_pkg::DTC_MODE_PRESCALE:
			begin
				// Upper three low bits are left as they are
				r[4:0] = l[4:0] + 5'h01;
				if (l[4:0] == dtc_pkg::PRESCALE_MAX)
				begin
					r[15:8] = h + 8'h01;
					r[16]   = (h == 8'hff);
				end
			end
			dtc_pkg::DTC_MODE_WIDE:
				r = wide;
			dtc_pkg::DTC_MODE_RELOAD:
			begin
				// Reload keeps the high byte untouched
				r[7:0] = lo9[8] ? h : lo9[7:0];
				r[16]  = lo9[8];
			end
			default:
				r = {1'b0, h, l};
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [1:0]  mode_a;
		logic [1:0]  mode_b;
		logic        src_a;
		logic        src_b;
		logic        inc_a;
		logic        inc_b;
		logic        run_b_eff;
		logic        set_ovf_a;
		logic        set_ovf_b;
		logic [16:0] r;
		logic [8:0]  sum;
		logic [7:0]  rd;
		logic        hit;
		mode_a    = s.tmode[dtc_pkg::POS_UNIT_A + dtc_pkg::OFS_MODE +: 2];
		mode_b    = s.tmode[dtc_pkg::POS_UNIT_B + dtc_pkg::OFS_MODE +: 2];
		src_a     = 1'b0;
		src_b     = 1'b0;
		inc_a     = 1'b0;
		inc_b     = 1'b0;
		run_b_eff = 1'b0;
		set_ovf_a = 1'b0;
		set_ovf_b = 1'b0;
		r         = '0;
		sum       = '0;
		rd        = 8'h00;
		hit       = 1'b0;
		next_s    = s;

		// Pin samples once per peripheral cycle
		if (tick)
			next_s.pin_prev = pin_q;

		// Count sources: tick, or high-then-low on count pin
		src_a = s.tmode[dtc_pkg::POS_UNIT_A + dtc_pkg::OFS_SELECT] ?
			(tick && s.pin_prev[0] && !pin_q[0]) : tick;
		src_b = s.tmode[dtc_pkg::POS_UNIT_B + dtc_pkg::OFS_SELECT] ?
			(tick && s.pin_prev[1] && !pin_q[1]) : tick;

		// Timer A with run and gate
		inc_a = src_a && s.ctrl[dtc_pkg::BIT_RUN_BIT_A]
			&& (!s.tmode[dtc_pkg::POS_UNIT_A + dtc_pkg::OFS_GATE]
			|| pin_q[2]);
		if (mode_a == dtc_pkg::DTC_MODE_SPLIT)
		begin
			if (inc_a)
			begin
				sum         = {1'b0, s.a_lo} + 9'h001;
				next_s.a_lo = sum[7:0];
				set_ovf_a   = sum[8];
			end
			// High byte borrows timer B run bit and flag
			if (tick && s.ctrl[dtc_pkg::BIT_RUN_BIT_B])
			begin
				sum         = {1'b0, s.a_hi} + 9'h001;
				next_s.a_hi = sum[7:0];
				set_ovf_b   = sum[8];
			end
		end
		else if (inc_a)
		begin
			r           = step(mode_a, s.a_hi, s.a_lo);
			next_s.a_hi = r[15:8];
			next_s.a_lo = r[7:0];
			set_ovf_a   = r[16];
		end

		// Timer B; with A split, only its mode and gate turn it on and off
		run_b_eff = (mode_a == dtc_pkg::DTC_MODE_SPLIT) ||
			s.ctrl[dtc_pkg::BIT_RUN_BIT_B];
		inc_b = src_b && run_b_eff
			&& (!s.tmode[dtc_pkg::POS_UNIT_B + dtc_pkg::OFS_GATE]
			|| pin_q[3])
			&& (mode_b != dtc_pkg::DTC_MODE_SPLIT);
		if (inc_b)
		begin
			r           = step(mode_b, s.b_hi, s.b_lo);
			next_s.b_hi = r[15:8];
			next_s.b_lo = r[7:0];
			if (mode_a != dtc_pkg::DTC_MODE_SPLIT)
				set_ovf_b = set_ovf_b || r[16];
		end

		// Overflow flags: acknowledge clears, a set wins
		if (vector_ack_timer_a)
			next_s.ctrl[dtc_pkg::BIT_OVERFLOW_FLAG_A] = 1'b0;
		if (set_ovf_a)
			next_s.ctrl[dtc_pkg::BIT_OVERFLOW_FLAG_A] = 1'b1;
		if (vector_ack_timer_b)
			next_s.ctrl[dtc_pkg::BIT_OVERFLOW_FLAG_B] = 1'b0;
		if (set_ovf_b)
			next_s.ctrl[dtc_pkg::BIT_OVERFLOW_FLAG_B] = 1'b1;

		// External A: falling edge or low level
		if (s.ctrl[dtc_pkg::BIT_EXT_IRQ_TYPE_A])
		begin
			if (vector_ack_ext_a)
				next_s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_A] = 1'b0;
			if (tick && s.pin_prev[2] && !pin_q[2])
				next_s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_A] = 1'b1;
		end
		else if (tick)
			next_s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_A] = !pin_q[2];

		// External B: falling edge or low level
		if (s.ctrl[dtc_pkg::BIT_EXT_IRQ_TYPE_B])
		begin
			if (vector_ack_ext_b)
				next_s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_B] = 1'b0;
			if (tick && s.pin_prev[3] && !pin_q[3])
				next_s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_B] = 1'b1;
		end
		else if (tick)
			next_s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_B] = !pin_q[3];

		// ----------------------------------------
		// AXI4-Lite write side
		// ----------------------------------------
		if (s_axi_awvalid && s.awready)
		begin
			next_s.aw_full = 1'b1;
			next_s.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.w_full = 1'b1;
			next_s.wbyte  = s_axi_wdata[7:0];
			next_s.wlane  = s_axi_wstrb[0];
		end
		if (s.aw_full && s.w_full && !s.bvalid)
		begin
			hit = 1'b1;
			next_s.bvalid = 1'b1;
			// Software write overrides hardware activity this cycle
			case (s.awaddr[AXI_ADDR_W-1:2])
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_TIMER_CONTROL):
					if (s.wlane) next_s.ctrl = s.wbyte;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_TIMER_MODE):
					if (s.wlane) next_s.tmode = s.wbyte;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_A_LOW):
					if (s.wlane) next_s.a_lo = s.wbyte;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_B_LOW):
					if (s.wlane) next_s.b_lo = s.wbyte;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_A_HIGH):
					if (s.wlane) next_s.a_hi = s.wbyte;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_B_HIGH):
					if (s.wlane) next_s.b_hi = s.wbyte;
				default:
					hit = 1'b0;
			endcase
			next_s.bresp = hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
		end
		if (s.bvalid && s_axi_bready)
		begin
			next_s.bvalid  = 1'b0;
			next_s.aw_full = 1'b0;
			next_s.w_full  = 1'b0;
		end
		next_s.awready = !next_s.aw_full;
		next_s.wready  = !next_s.w_full;

		// ----------------------------------------
		// AXI4-Lite read side
		// ----------------------------------------
		if (s_axi_arvalid && s.arready)
		begin
			hit = 1'b1;
			case (s_axi_araddr[AXI_ADDR_W-1:2])
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_TIMER_CONTROL):  rd = s.ctrl;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_TIMER_MODE):     rd = s.tmode;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_A_LOW):  rd = s.a_lo;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_B_LOW):  rd = s.b_lo;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_A_HIGH): rd = s.a_hi;
				(AXI_ADDR_W-2)'(dtc_pkg::IDX_COUNTER_B_HIGH): rd = s.b_hi;
				default:
				begin
					rd  = 8'h00;
					hit = 1'b0;
				end
			endcase
			next_s.rvalid = 1'b1;
			next_s.rdata  = {24'h000000, rd};
			next_s.rresp  = hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		next_s.arready = !next_s.rvalid;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= RST_STATE;
		else
			s <= next_s;
	end

	// ----------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------
	assign s_axi_awready   = s.awready;
	assign s_axi_wready    = s.wready;
	assign s_axi_bvalid    = s.bvalid;
	assign s_axi_bresp     = s.bresp;
	assign s_axi_arready   = s.arready;
	assign s_axi_rvalid    = s.rvalid;
	assign s_axi_rresp     = s.rresp;
	assign s_axi_rdata     = s.rdata;
	assign overflow_flag_a = s.ctrl[dtc_pkg::BIT_OVERFLOW_FLAG_A];
	assign overflow_flag_b = s.ctrl[dtc_pkg::BIT_OVERFLOW_FLAG_B];
	assign ext_irq_flag_a  = s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_A];
	assign ext_irq_flag_b  = s.ctrl[dtc_pkg::BIT_EXT_IRQ_FLAG_B];

endmodule
`default_nettype wire

// *** test/dtc_top_asserts.sv ***
// Checker on the ports of the dual timer/counter
`timescale 1ns/1ns
`default_nettype none
module dtc_top_asserts (
	// Clock, reset and bus
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	// Pins and flags
	input wire logic        ext_irq_pin_a_n,
	input wire logic        vector_ack_timer_a,
	input wire logic        overflow_flag_a,
	input wire logic        ext_irq_flag_a
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// Cycles since pin a was low, saturating
	// ----------------------------------------
	logic [4:0] since_low;
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			since_low <= 5'h1f;
		else if (!ext_irq_pin_a_n)
			since_low <= 5'h00;
		else if (since_low != 5'h1f)
			since_low <= since_low + 5'h01;

	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_awready ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
	property p_b_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("write taken early");
	property p_b_legal;
		s_axi_bvalid |-> s_axi_bresp == dtc_pkg::RESP_OKAY
			|| s_axi_bresp == dtc_pkg::RESP_SLVERR;
	endproperty
	a_b_legal: assert property (p_b_legal) else $error("bad write response");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
	property p_r_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_busy: assert property (p_r_busy) else $error("read taken early");
	property p_r_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_r_zero: assert property (p_r_zero) else $error("upper read bits set");
	property p_ack_a;
		vector_ack_timer_a |=> !overflow_flag_a;
	endproperty
	a_ack_a: assert property (p_ack_a) else $error("overflow a not cleared");
	property p_ext_cause;
		$rose(ext_irq_flag_a) |-> (since_low < 5'h10 || s_axi_bvalid)
			or (##1 s_axi_bvalid);
	endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("ext a flag uncaused");

	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == dtc_pkg::RESP_SLVERR);
	c_read: cover property (s_axi_rvalid);
	c_ovf: cover property ($rose(overflow_flag_a));
endmodule

bind dtc_top dtc_top_asserts i_dtc_top_asserts (
	.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .ext_irq_pin_a_n,
	.vector_ack_timer_a, .overflow_flag_a, .ext_irq_flag_a
);
`default_nettype wire

// *** test/dtc_pins_model.sv ***
// Driver standing in for the external count and interrupt pins
`timescale 1ns/1ns
`default_nettype none
module dtc_pins_model (
	// Clock
	input  wire logic       clk,
	// Count a, count b, ext a_n, ext b_n
	output logic      [3:0] pin
);
	initial
		pin = 4'hf;

	// Two peripheral cycles per level, so no level goes unsampled
	task automatic fall(input int p, input int n);
		repeat (n)
		begin
			repeat (12) @(posedge clk);
			pin[p] <= 1'b0;
			repeat (12) @(posedge clk);
			pin[p] <= 1'b1;
		end
		repeat (12) @(posedge clk);
	endtask

	task automatic lvl(input int p, input logic b);
		@(posedge clk);
		pin[p] <= b;
	endtask
endmodule
`default_nettype wire

// *** test/dtc_top_tb.sv ***
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`default_nettype none
module dtc_top_tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h1;
	logic [3:0]  vack = 4'h0;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [3:0]  pin, flg;
	logic [1:0]  r;
	logic [7:0]  v, tab [5] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d};
	int          miscompares = 0, n_compared = 0;

	always #5 clk = ~clk;

	dtc_top i_dtc_top (
		.clk, .reset_n,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.count_pin_a(pin[0]), .count_pin_b(pin[1]),
		.ext_irq_pin_a_n(pin[2]), .ext_irq_pin_b_n(pin[3]),
		.vector_ack_timer_a(vack[0]), .vector_ack_timer_b(vack[1]),
		.vector_ack_ext_a(vack[2]), .vector_ack_ext_b(vack[3]),
		.overflow_flag_a(flg[0]), .overflow_flag_b(flg[1]),
		.ext_irq_flag_a(flg[2]), .ext_irq_flag_b(flg[3])
	);
	dtc_pins_model i_dtc_pins_model (.clk, .pin);

	task chk(input logic [31:0] s, e, input string m);
		n_compared++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task wr(input logic [7:0] i, d);
		@(posedge clk);
		awaddr <= {2'h0, i, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		r = bresp;
	endtask

	task rd(input logic [7:0] i);
		@(posedge clk);
		araddr <= {2'h0, i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		v = rdata[7:0];
		r = rresp;
	endtask

	task rc(input logic [7:0] i, e);
		rd(i);
		chk(v, e, "register value");
		chk(r, dtc_pkg::RESP_OKAY, "read response");
	endtask

	// Stop, set mode and two bytes, then restart
	task go(input logic [7:0] m, i1, d1, i2, d2, c);
		wr(8'h88, 8'h05);
		wr(8'h89, m);
		wr(i1, d1);
		wr(i2, d2);
		wr(8'h88, c);
	endtask

	task fl(input int p, input int n);
		i_dtc_pins_model.fall(p, n);
	endtask

	task ack(input int k);
		@(posedge clk);
		vack[k] <= 1'b1;
		@(posedge clk);
		vack[k] <= 1'b0;
		@(negedge clk);
	endtask

	// Peripheral ticks seen in n clock edges, give or take one
	function automatic int ticks_in(input int n);
		return n / dtc_pkg::PERIPH_DIV;
	endfunction

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Whole run is under two thousand cycles; this leaves wide margin
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		close_out();
	end

	initial
	begin
		logic [7:0] i, d;
		void'($urandom(72));
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 6; k++)
			rc(8'h88 + 8'(k), 8'h00);
		rd(8'h90);
		chk(r, dtc_pkg::RESP_SLVERR, "unmapped read");
		wr(8'h90, 8'h55);
		chk(r, dtc_pkg::RESP_SLVERR, "unmapped write");
		repeat (10)
		begin
			i = tab[$urandom_range(4)];
			d = 8'($urandom);
			// Split mode would free-run timer B under the read-back
			if (i == 8'h89 && d[1:0] == 2'h3)
				d[0] = 1'b0;
			wr(i, d);
			chk(r, dtc_pkg::RESP_OKAY, "write response");
			rc(i, d);
		end
		d = 8'($urandom) & 8'hae | 8'h05;
		wr(8'h88, d);
		rc(8'h88, d);
		chk(flg, {d[3], d[1], d[7], d[5]}, "flag outputs");
		for (int k = 0; k < 4; k++)
			ack(k);
		rc(8'h88, 8'h05);
		go(8'h05, 8'h8c, 8'hff, 8'h8a, 8'hfd, 8'h15);
		fl(0, 3);
		rc(8'h8a, 8'h00);
		rc(8'h8c, 8'h00);
		chk(flg[0], 1'b1, "overflow a");
		wr(8'h88, 8'h25);
		fl(0, 2);
		rc(8'h8a, 8'h00);
		go(8'h04, 8'h8a, 8'h1f, 8'h8c, 8'h05, 8'h15);
		fl(0, 1);
		rc(8'h8c, 8'h06);
		rd(8'h8a);
		chk(v & 8'h1f, 8'h00, "prescaler wrap");
		go(8'h0d, 8'h8a, 8'h10, 8'h8a, 8'h10, 8'h15);
		i_dtc_pins_model.lvl(2, 1'b0);
		fl(0, 2);
		rc(8'h8a, 8'h10);
		i_dtc_pins_model.lvl(2, 1'b1);
		fl(0, 1);
		rc(8'h8a, 8'h11);
		go(8'h60, 8'h8d, 8'h80, 8'h8b, 8'hff, 8'h45);
		fl(1, 1);
		rc(8'h8b, 8'h80);
		rc(8'h8d, 8'h80);
		chk(flg[1], 1'b1, "overflow b");
		go(8'h70, 8'h8b, 8'h80, 8'h8b, 8'h80, 8'h45);
		fl(1, 2);
		rc(8'h8b, 8'h80);
		wstrb <= 4'h0;
		wr(8'h89, 8'h00);
		chk(r, dtc_pkg::RESP_OKAY, "masked write");
		wstrb <= 4'h1;
		rc(8'h89, 8'h70);
		wr(8'h88, 8'h04);
		fl(3, 1);
		chk(flg[3], 1'b1, "edge flag b");
		ack(3);
		chk(flg[3], 1'b0, "edge ack b");
		i_dtc_pins_model.lvl(2, 1'b0);
		repeat (20) @(negedge clk);
		chk(flg[2], 1'b1, "level flag a");
		ack(2);
		chk(flg[2], 1'b1, "level ack a");
		i_dtc_pins_model.lvl(2, 1'b1);
		repeat (20) @(negedge clk);
		chk(flg[2], 1'b0, "level release a");
		i_dtc_pins_model.lvl(3, 1'b0);
		go(8'h90, 8'h8b, 8'h00, 8'h8b, 8'h00, 8'h45);
		repeat (60) @(posedge clk);
		rc(8'h8b, 8'h00);
		i_dtc_pins_model.lvl(3, 1'b1);
		repeat (60) @(posedge clk);
		wr(8'h88, 8'h05);
		rd(8'h8b);
		chk(v - 8'(ticks_in(61)) <= 8'h01, 1'b1, "gate b open");
		go(8'h01, 8'h8a, 8'h00, 8'h8a, 8'h00, 8'h15);
		repeat (600) @(posedge clk);
		wr(8'h88, 8'h05);
		rd(8'h8a);
		d = v;
		chk(d - 8'(ticks_in(604)) <= 8'h01, 1'b1, "tick count");
		repeat (60) @(posedge clk);
		rc(8'h8a, d);
		go(8'h03, 8'h8a, 8'h10, 8'h8c, 8'hf8, 8'h45);
		repeat (120) @(posedge clk);
		chk(flg[1:0], 2'b10, "split flags");
		wr(8'h88, 8'h05);
		rc(8'h8a, 8'h10);
		rd(8'h8c);
		chk(v - 8'(248 + ticks_in(124)) <= 8'h01, 1'b1, "split high");
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 6; k++)
			rc(8'h88 + 8'(k), 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
